/* pmx_pkg.sv */
/*
 * Shared constants for the pin controller: pin count, special pin positions,
 * register byte offsets, reset values and the function-select encoding.
 * Assumes a 32-bit classic Wishbone register bus with byte addressing.
 */
package pmx_pkg;

	// Pin population and bus widths.
	localparam int PMX_PINS   = 37;
	localparam int PMX_ADR_W  = 8;
	localparam int PMX_DAT_W  = 32;
	localparam int PMX_SEL_W  = 4;
	localparam int PMX_STRAPS = 4;

	// Pins with fixed roles.
	localparam int PMX_STRAP_LSB     = 33;
	localparam int PMX_EXP_CLK_PIN   = 0;
	localparam int PMX_EXP_DO_PIN    = 1;
	localparam int PMX_EXP_DI_PIN    = 2;
	localparam int PMX_EXP_LD_PIN    = 3;
	localparam int PMX_MGMT_CLK_PIN  = 22;
	localparam int PMX_MGMT_DATA_PIN = 23;

	// Strap code that selects the management slave mode.
	localparam logic [PMX_STRAPS-1:0] PMX_MGMT_SLAVE_STRAP = 4'hF;

	// Each 37-bit register takes a pair of words: low bits, then bits 36:32.
	localparam logic [PMX_ADR_W-1:0] PMX_OFS_OUT      = 8'h00;
	localparam logic [PMX_ADR_W-1:0] PMX_OFS_OUT_SET  = 8'h08;
	localparam logic [PMX_ADR_W-1:0] PMX_OFS_OUT_CLR  = 8'h10;
	localparam logic [PMX_ADR_W-1:0] PMX_OFS_IN       = 8'h18;
	localparam logic [PMX_ADR_W-1:0] PMX_OFS_OE       = 8'h20;
	localparam logic [PMX_ADR_W-1:0] PMX_OFS_FSEL0    = 8'h28;
	localparam logic [PMX_ADR_W-1:0] PMX_OFS_FSEL1    = 8'h30;
	localparam logic [PMX_ADR_W-1:0] PMX_OFS_PEND     = 8'h38;
	localparam logic [PMX_ADR_W-1:0] PMX_OFS_IRQ_ENA  = 8'h40;
	localparam logic [PMX_ADR_W-1:0] PMX_OFS_IRQ_ID   = 8'h48;
	localparam logic [PMX_ADR_W-1:0] PMX_OFS_STRAP    = 8'h50;
	localparam int                   PMX_HI_WORD_BIT  = 2;

	// Reset values.
	localparam logic [PMX_PINS-1:0] PMX_RST_OUT  = 37'h0;
	localparam logic [PMX_PINS-1:0] PMX_RST_OE   = 37'h0;
	localparam logic [PMX_PINS-1:0] PMX_RST_FSEL = 37'h0;
	localparam logic [PMX_PINS-1:0] PMX_RST_PEND = 37'h0;
	localparam logic [PMX_PINS-1:0] PMX_RST_ENA  = 37'h0;

	// Per-pin function code built from the two selection registers.
	typedef enum logic [1:0] {
		PMX_FN_PIN  = 2'h0,
		PMX_FN_ALT1 = 2'h1,
		PMX_FN_ALT2 = 2'h2,
		PMX_FN_ALT3 = 2'h3
	} pmx_func_t;

endpackage : pmx_pkg

/* pmx_pin_io_mux_controller.sv */
/*
 * General-purpose pin controller: direction, output value with atomic set and
 * clear, synchronised input, two-bit function multiplexer, strap capture at
 * reset, change detection with masked level interrupt, classic Wishbone slave.
 * Assumes pin inputs are asynchronous levels, rst_i is the external device
 * reset held for at least three clocks, and soft_rst_i is the software reset.
 */
`timescale 1ns/1ps

// Behaviour
// - Pins not taken by a function select or slave mode are inputs after reset; direction bits enable outputs.
// - Input register shows every pin level.
// - Output pins drive their output value bit.
// - Atomic set register sets written-one output bits.
// - Atomic clear register clears written-one output bits.
// - Function selects survive software reset, external only.
// - Two-bit code: 0 pin, 1 alt one, 2 alt two, 3 alt three.
// - Pins 0-3 alt one carry expander signals.
// - Management slave strap takes over its two pins.
// - Straps sampled and latched while reset asserted.
// - Strap pins are ordinary pins after reset.
// - Any input change sets its pending bit.
// - Pending bit interrupts only when enabled.
// - Identity register is pending AND enable.
module pmx_pin_io_mux_controller (
	// Clock and resets.
	input  wire logic                           clk_i,
	input  wire logic                           rst_i,
	input  wire logic                           soft_rst_i,
	// Wishbone slave.
	input  wire logic                           cyc_i,
	input  wire logic                           stb_i,
	input  wire logic                           we_i,
	input  wire logic [pmx_pkg::PMX_ADR_W-1:0]  adr_i,
	input  wire logic [pmx_pkg::PMX_SEL_W-1:0]  sel_i,
	input  wire logic [pmx_pkg::PMX_DAT_W-1:0]  dat_i,
	output logic      [pmx_pkg::PMX_DAT_W-1:0]  dat_o,
	output logic                                ack_o,
	output logic                                err_o,
	// Pins.
	input  wire logic [pmx_pkg::PMX_PINS-1:0]   pin_i,
	output logic      [pmx_pkg::PMX_PINS-1:0]   pin_o,
	output logic      [pmx_pkg::PMX_PINS-1:0]   pin_oe_o,
	// Alternate peripherals, one output and enable per pin and function.
	input  wire logic [pmx_pkg::PMX_PINS-1:0]   alt1_out_i,
	input  wire logic [pmx_pkg::PMX_PINS-1:0]   alt1_oe_i,
	input  wire logic [pmx_pkg::PMX_PINS-1:0]   alt2_out_i,
	input  wire logic [pmx_pkg::PMX_PINS-1:0]   alt2_oe_i,
	input  wire logic [pmx_pkg::PMX_PINS-1:0]   alt3_out_i,
	input  wire logic [pmx_pkg::PMX_PINS-1:0]   alt3_oe_i,
	output logic      [pmx_pkg::PMX_PINS-1:0]   alt_in_o,
	// Serial pin-expander signals.
	input  wire logic                           expander_shift_clock_i,
	input  wire logic                           expander_data_out_i,
	input  wire logic                           expander_load_i,
	output logic                                expander_data_in_o,
	// Management slave signals.
	output logic                                mgmt_slave_clock_pin_o,
	output logic                                mgmt_slave_data_pin_o,
	input  wire logic                           mgmt_slave_data_pin_i,
	input  wire logic                           mgmt_slave_data_oe_i,
	output logic                                mgmt_slave_mode_o,
	// Straps and interrupt.
	output logic      [pmx_pkg::PMX_STRAPS-1:0] cpu_config_straps_o,
	output logic                                irq_o
);
	import pmx_pkg::*;

	logic [PMX_PINS-1:0]   sync_a_ff;
	logic [PMX_PINS-1:0]   sync_b_ff;
	logic [PMX_PINS-1:0]   prev_ff;
	logic [PMX_PINS-1:0]   out_ff;
	logic [PMX_PINS-1:0]   oe_ff;
	logic [PMX_PINS-1:0]   fsel0_ff;
	logic [PMX_PINS-1:0]   fsel1_ff;
	logic [PMX_PINS-1:0]   pend_ff;
	logic [PMX_PINS-1:0]   ena_ff;
	logic [PMX_STRAPS-1:0] strap_ff;
	logic [PMX_PINS-1:0]   pin_ff;
	logic [PMX_PINS-1:0]   pin_oe_ff;
	logic [PMX_DAT_W-1:0]  dat_ff;
	logic                  ack_ff;
	logic                  err_ff;
	logic                  irq_ff;
	logic                  mode_ff;
	logic                  any_rst;
	logic                  req;
	logic                  hit;
	logic                  wr;
	logic [PMX_ADR_W-1:0]  pair_adr;
	logic                  hi_word;
	logic [63:0]           wdat64;
	logic [63:0]           wmsk64;
	logic [PMX_PINS-1:0]   wdat;
	logic [PMX_PINS-1:0]   wmsk;
	logic [PMX_PINS-1:0]   rd_val;
	logic [63:0]           rd64;
	logic [PMX_DAT_W-1:0]  nxt_dat;
	logic [PMX_PINS-1:0]   nxt_pin;
	logic [PMX_PINS-1:0]   nxt_pin_oe;

	// Expand byte selects into a bit mask for one 32-bit word.
	function automatic logic [PMX_DAT_W-1:0] lane_mask(input logic [PMX_SEL_W-1:0] s);
		lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction : lane_mask

	assign any_rst   = rst_i | soft_rst_i;

	// Bus request decode; a new request is taken only while no answer is out.
	assign req      = cyc_i & stb_i & ~ack_ff & ~err_ff;
	assign hi_word  = adr_i[PMX_HI_WORD_BIT];
	assign pair_adr = {adr_i[PMX_ADR_W-1:3], 3'h0};
	assign hit      = (adr_i[1:0] == 2'h0) && (pair_adr <= PMX_OFS_STRAP);
	assign wr       = req & hit & we_i;

	// Place written data and lanes on the addressed half of the 37-bit value.
	assign wdat64 = hi_word ? {dat_i, 32'h0} : {32'h0, dat_i};
	assign wmsk64 = hi_word ? {lane_mask(sel_i), 32'h0} : {32'h0, lane_mask(sel_i)};
	assign wdat   = wdat64[PMX_PINS-1:0];
	assign wmsk   = wmsk64[PMX_PINS-1:0];

	// Two-stage synchroniser; no reset so straps are valid during reset.
	always_ff @(posedge clk_i)
	begin
		sync_a_ff <= pin_i;
		sync_b_ff <= sync_a_ff;
		prev_ff   <= sync_b_ff;
	end

	// Straps follow the pins while reset is held and freeze at release.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			strap_ff <= sync_b_ff[PMX_STRAP_LSB +: PMX_STRAPS];
			mode_ff  <= (sync_b_ff[PMX_STRAP_LSB +: PMX_STRAPS] == PMX_MGMT_SLAVE_STRAP);
		end
	end

	// Output value with plain, set and clear views, merged in one step.
	always_ff @(posedge clk_i)
	begin
		if (any_rst)
			out_ff <= PMX_RST_OUT;
		else if (wr && pair_adr == PMX_OFS_OUT)
			out_ff <= (out_ff & ~wmsk) | (wdat & wmsk);
		else if (wr && pair_adr == PMX_OFS_OUT_SET)
			out_ff <= out_ff | (wdat & wmsk);
		else if (wr && pair_adr == PMX_OFS_OUT_CLR)
			out_ff <= out_ff & ~(wdat & wmsk);
	end

	// Direction register; zero means input, so pins not taken by a function select or slave mode start as inputs.
	always_ff @(posedge clk_i)
	begin
		if (any_rst)
			oe_ff <= PMX_RST_OE;
		else if (wr && pair_adr == PMX_OFS_OE)
			oe_ff <= (oe_ff & ~wmsk) | (wdat & wmsk);
	end

	// Function selects see only the external reset, so a software reset keeps
	// the pin mapping; the pin drivers are still released while it lasts.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			fsel0_ff <= PMX_RST_FSEL;
			fsel1_ff <= PMX_RST_FSEL;
		end
		else if (wr && pair_adr == PMX_OFS_FSEL0)
			fsel0_ff <= (fsel0_ff & ~wmsk) | (wdat & wmsk);
		else if (wr && pair_adr == PMX_OFS_FSEL1)
			fsel1_ff <= (fsel1_ff & ~wmsk) | (wdat & wmsk);
	end

	// Interrupt enable mask.
	always_ff @(posedge clk_i)
	begin
		if (any_rst)
			ena_ff <= PMX_RST_ENA;
		else if (wr && pair_adr == PMX_OFS_IRQ_ENA)
			ena_ff <= (ena_ff & ~wmsk) | (wdat & wmsk);
	end

	// Change pending: a change seen in the clearing cycle stays set.
	always_ff @(posedge clk_i)
	begin
		if (any_rst)
			pend_ff <= PMX_RST_PEND;
		else if (wr && pair_adr == PMX_OFS_PEND)
			pend_ff <= (pend_ff & ~(wdat & wmsk)) | (sync_b_ff ^ prev_ff);
		else
			pend_ff <= pend_ff | (sync_b_ff ^ prev_ff);
	end

	// Level interrupt from enabled pending bits.
	always_ff @(posedge clk_i)
	begin
		if (any_rst)
			irq_ff <= 1'b0;
		else
			irq_ff <= |(pend_ff & ena_ff);
	end

	// Read multiplexer over the addressed register pair.
	always_comb
	begin
		rd_val = '0;
		if (pair_adr == PMX_OFS_OUT)
			rd_val = out_ff;
		else if (pair_adr == PMX_OFS_IN)
			rd_val = sync_b_ff;
		else if (pair_adr == PMX_OFS_OE)
			rd_val = oe_ff;
		else if (pair_adr == PMX_OFS_FSEL0)
			rd_val = fsel0_ff;
		else if (pair_adr == PMX_OFS_FSEL1)
			rd_val = fsel1_ff;
		else if (pair_adr == PMX_OFS_PEND)
			rd_val = pend_ff;
		else if (pair_adr == PMX_OFS_IRQ_ENA)
			rd_val = ena_ff;
		else if (pair_adr == PMX_OFS_IRQ_ID)
			rd_val = pend_ff & ena_ff;
		else if (pair_adr == PMX_OFS_STRAP)
			rd_val = {{(PMX_PINS-PMX_STRAPS){1'b0}}, strap_ff};
		rd64    = {{(64-PMX_PINS){1'b0}}, rd_val};
		nxt_dat = hi_word ? rd64[63:32] : rd64[31:0];
	end

	// Bus answer: one cycle after the request, held a single cycle. Set and
	// clear views and the identity register read as zero or live value.
	always_ff @(posedge clk_i)
	begin
		if (any_rst)
		begin
			ack_ff <= 1'b0;
			err_ff <= 1'b0;
			dat_ff <= 32'h0;
		end
		else
		begin
			ack_ff <= req & hit;
			err_ff <= req & ~hit;
			if (req & hit & ~we_i)
				dat_ff <= nxt_dat;
		end
	end

	// Per-pin function multiplexer; outputs are registered, costing one cycle.
	generate
		for (genvar n = 0; n < PMX_PINS; n++)
		begin : g_pin
			always_comb
			begin
				nxt_pin[n]    = out_ff[n];
				nxt_pin_oe[n] = oe_ff[n];
				case (pmx_func_t'({fsel1_ff[n], fsel0_ff[n]}))
					PMX_FN_ALT1:
					begin
						nxt_pin[n]    = alt1_out_i[n];
						nxt_pin_oe[n] = alt1_oe_i[n];
						if (n == PMX_EXP_CLK_PIN)
						begin
							nxt_pin[n]    = expander_shift_clock_i;
							nxt_pin_oe[n] = 1'b1;
						end
						else if (n == PMX_EXP_DO_PIN)
						begin
							nxt_pin[n]    = expander_data_out_i;
							nxt_pin_oe[n] = 1'b1;
						end
						else if (n == PMX_EXP_DI_PIN)
						begin
							nxt_pin[n]    = 1'b0;
							nxt_pin_oe[n] = 1'b0;
						end
						else if (n == PMX_EXP_LD_PIN)
						begin
							nxt_pin[n]    = expander_load_i;
							nxt_pin_oe[n] = 1'b1;
						end
					end
					PMX_FN_ALT2:
					begin
						nxt_pin[n]    = alt2_out_i[n];
						nxt_pin_oe[n] = alt2_oe_i[n];
					end
					PMX_FN_ALT3:
					begin
						nxt_pin[n]    = alt3_out_i[n];
						nxt_pin_oe[n] = alt3_oe_i[n];
					end
					default:
						nxt_pin[n] = out_ff[n];
				endcase
				// The strapped slave mode wins over any function selection.
				if (mode_ff && n == PMX_MGMT_CLK_PIN)
				begin
					nxt_pin[n]    = 1'b0;
					nxt_pin_oe[n] = 1'b0;
				end
				else if (mode_ff && n == PMX_MGMT_DATA_PIN)
				begin
					nxt_pin[n]    = mgmt_slave_data_pin_i;
					nxt_pin_oe[n] = mgmt_slave_data_oe_i;
				end
			end
		end
	endgenerate

	// Pin drivers; released during any reset so every pin floats as input.
	always_ff @(posedge clk_i)
	begin
		if (any_rst)
		begin
			pin_ff    <= 37'h0;
			pin_oe_ff <= 37'h0;
		end
		else
		begin
			pin_ff    <= nxt_pin;
			pin_oe_ff <= nxt_pin_oe;
		end
	end

	assign dat_o                  = dat_ff;
	assign ack_o                  = ack_ff;
	assign err_o                  = err_ff;
	assign pin_o                  = pin_ff;
	assign pin_oe_o               = pin_oe_ff;
	assign alt_in_o               = sync_b_ff;
	assign expander_data_in_o     = sync_b_ff[PMX_EXP_DI_PIN];
	assign mgmt_slave_clock_pin_o = sync_b_ff[PMX_MGMT_CLK_PIN];
	assign mgmt_slave_data_pin_o  = sync_b_ff[PMX_MGMT_DATA_PIN];
	assign mgmt_slave_mode_o      = mode_ff;
	assign cpu_config_straps_o    = strap_ff;
	assign irq_o                  = irq_ff;

endmodule : pmx_pin_io_mux_controller

/* pmx_monitor.sv */
/*
 * Checker for the pin controller, watching only its top-level ports.
 * Assumes it is bound to the controller, as the statement at the foot does.
 */
`timescale 1ns/1ps
module pmx_monitor
	import pmx_pkg::*;
(
	// Clock, reset and bus.
	input wire logic                   clk_i,
	input wire logic                   rst_i,
	input wire logic                   cyc_i,
	input wire logic                   stb_i,
	input wire logic [PMX_ADR_W-1:0]   adr_i,
	input wire logic                   ack_o,
	input wire logic                   err_o,
	// Pins and side outputs.
	input wire logic [PMX_PINS-1:0]    pin_i,
	input wire logic [PMX_PINS-1:0]    pin_oe_o,
	input wire logic [PMX_PINS-1:0]    alt_in_o,
	input wire logic                   expander_data_in_o,
	input wire logic                   mgmt_slave_clock_pin_o,
	input wire logic                   mgmt_slave_mode_o,
	input wire logic [PMX_STRAPS-1:0]  cpu_config_straps_o,
	input wire logic                   irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// A request that the slave has not answered yet, and its answer.
	sequence s_req;
		cyc_i && stb_i && !ack_o && !err_o;
	endsequence
	sequence s_answer;
		ack_o ^ err_o;
	endsequence

	// Bus answers come exactly one cycle after the taking edge and last one cycle.
	a_bus_answer_once: assert property (s_req |=> s_answer)
		else $error("bus request not answered once");
	a_ack_one_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack held longer than a cycle");
	a_misaligned_err: assert property (s_req ##0 (adr_i[1:0] != 2'h0) |=> err_o)
		else $error("misaligned access not refused");
	// Reset must be checked while reset is high, so the default disable is overridden.
	a_quiet_in_reset: assert property (disable iff (1'b0)
		rst_i |=> !ack_o && !irq_o && pin_oe_o == '0)
		else $error("outputs active during reset");
	a_input_two_stage: assert property (alt_in_o == $past(pin_i, 2))
		else $error("input pipeline depth wrong");
	a_straps_frozen: assert property (!$past(rst_i) |-> $stable(cpu_config_straps_o))
		else $error("straps moved outside reset");
	// The expander data and slave clock outputs are compared with the pin two edges back, not with another
	// copy of the same flop, so a wrong tap would be caught.
	a_expander_din: assert property (
		expander_data_in_o == $past(pin_i[PMX_EXP_DI_PIN], 2))
		else $error("expander data in not pin 2");
	a_mgmt_mode_code: assert property (
		mgmt_slave_mode_o == (cpu_config_straps_o == PMX_MGMT_SLAVE_STRAP))
		else $error("slave mode does not follow straps");
	a_mgmt_clk_input: assert property (mgmt_slave_mode_o |-> !pin_oe_o[PMX_MGMT_CLK_PIN])
		else $error("slave clock pin not an input");
	a_mgmt_clk_sync: assert property (
		mgmt_slave_clock_pin_o == $past(pin_i[PMX_MGMT_CLK_PIN], 2))
		else $error("slave clock pin not synchronised");
endmodule : pmx_monitor

bind pmx_pin_io_mux_controller pmx_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
	.stb_i(stb_i), .adr_i(adr_i), .ack_o(ack_o), .err_o(err_o), .pin_i(pin_i),
	.pin_oe_o(pin_oe_o), .alt_in_o(alt_in_o), .expander_data_in_o(expander_data_in_o),
	.mgmt_slave_clock_pin_o(mgmt_slave_clock_pin_o), .mgmt_slave_mode_o(mgmt_slave_mode_o),
	.cpu_config_straps_o(cpu_config_straps_o), .irq_o(irq_o));

/* pmx_board.sv */
/*
 * Board model: each pin follows the controller while it drives, else a bench level.
 * Assumes no pull resistors, so an undriven pin shows whatever the bench sets.
 */
`timescale 1ns/1ps
module pmx_board (
	// Controller drive.
	input  wire logic [36:0] pin_o,
	input  wire logic [36:0] pin_oe_o,
	// Bench level and resulting pin.
	input  wire logic [36:0] board_i,
	output logic      [36:0] pin_i
);
	// A driven pin reads back its own value; the bench never fights the controller.
	assign pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & board_i);
endmodule : pmx_board

/* test_pin_io_mux_controller.sv */
/*
 * Self-checking bench for the pin controller with a board model on its pins.
 * Assumes the Wishbone answer of one cycle and the two-stage input pipeline.
 */
`timescale 1ns/1ps
module test_pin_io_mux_controller;
	import pmx_pkg::*;
	logic        clk_i = 1'b0, rst_i = 1'b1, soft_rst_i = 1'b0;
	logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o, err_o, bus_e;
	logic [7:0]  adr_i = 8'h00;
	logic [3:0]  sel_i = 4'h0, straps;
	logic [31:0] dat_i = '0, dat_o, bus_q;
	logic [36:0] pin_i, pin_o, pin_oe_o, alt_in_o, board = 37'h00ABCD0000;
	logic [36:0] alt_oe = '1, alt2 = 37'h10, alt3 = 37'h20;
	logic        din, mclk, mdat, mmode, irq_o, exp_clk = 1'b1, mdata = 1'b0, moe = 1'b0;
	int          error_cnt = 0, total_checks = 0;

	// The clock inverts every half period of 2 ns.
	always #2 clk_i = ~clk_i;

	pmx_pin_io_mux_controller u_dut (.clk_i(clk_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .pin_i(pin_i), .pin_o(pin_o),
		.pin_oe_o(pin_oe_o), .alt1_out_i(37'h0), .alt1_oe_i(alt_oe), .alt2_out_i(alt2),
		.alt2_oe_i(alt_oe), .alt3_out_i(alt3), .alt3_oe_i(alt_oe), .alt_in_o(alt_in_o),
		.expander_shift_clock_i(exp_clk), .expander_data_out_i(1'b0),
		.expander_load_i(exp_clk), .expander_data_in_o(din), .mgmt_slave_clock_pin_o(mclk),
		.mgmt_slave_data_pin_o(mdat), .mgmt_slave_data_pin_i(mdata),
		.mgmt_slave_data_oe_i(moe), .mgmt_slave_mode_o(mmode),
		.cpu_config_straps_o(straps), .irq_o(irq_o));
	pmx_board u_board (.pin_o(pin_o), .pin_oe_o(pin_oe_o), .board_i(board), .pin_i(pin_i));

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One classic cycle; the request is held until ack or err is sampled high.
	task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= wr;
		adr_i <= a;
		sel_i <= 4'hF;
		dat_i <= d;
		do
		begin
			@(posedge clk_i);
			n++;
		end while (!(ack_o | err_o) && n < 20);
		if (n >= 20)
			check(1'b0, 1'b1);
		bus_q = dat_o;
		bus_e = err_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask : wb

	task automatic settle(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : settle

	// Reset with given strap levels, then look at the captured state.
	task automatic t_reset(input logic [3:0] s);
		@(posedge clk_i);
		rst_i <= 1'b1;
		board[36:33] <= s;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		settle(1);
		check(pin_oe_o, 37'h0);
		check(straps, s);
		check(mmode, s == PMX_MGMT_SLAVE_STRAP);
		wb(1'b0, PMX_OFS_FSEL0, 32'h0);
		check(bus_q, 32'h0);
		$display("reset test done");
	endtask : t_reset

	// Output, direction, back-to-back set and clear, a bad address, input levels.
	task automatic t_io;
		wb(1'b1, PMX_OFS_OE, 32'h0000FFFF);
		wb(1'b1, PMX_OFS_OUT, 32'h00000F0F);
		wb(1'b1, PMX_OFS_OUT_SET, 32'h000000F0);
		wb(1'b1, PMX_OFS_OUT_CLR, 32'h00000F00);
		wb(1'b0, PMX_OFS_OUT, 32'h0);
		check(bus_q, 32'h000000FF);
		settle(1);
		check({pin_oe_o[31:0], pin_o[31:0]}, 64'h0000FFFF_000000FF);
		@(posedge clk_i);
		board[36:33] <= 4'h5;
		settle(4);
		wb(1'b0, PMX_OFS_IN, 32'h0);
		check(bus_q, 32'hABCD00FF);
		wb(1'b0, PMX_OFS_IN + 8'h04, 32'h0);
		check(bus_q, 32'h0000000A);
		check(alt_in_o, 37'h0AABCD00FF);
		check({din, mclk, mdat}, 3'h7);
		wb(1'b0, 8'h61, 32'h0);
		check(bus_e, 1'b1);
		$display("io test done");
	endtask : t_io

	// Change detection, enable mask, identity and write-one clear.
	task automatic t_irq;
		wb(1'b1, PMX_OFS_PEND, 32'hFFFFFFFF);
		wb(1'b1, PMX_OFS_PEND + 8'h04, 32'h0000001F);
		wb(1'b1, PMX_OFS_IRQ_ENA, 32'h00010000);
		settle(2);
		check(irq_o, 1'b0);
		@(posedge clk_i);
		board[17:16] <= ~board[17:16];
		settle(6);
		check(irq_o, 1'b1);
		wb(1'b0, PMX_OFS_IRQ_ID, 32'h0);
		check(bus_q, 32'h00010000);
		wb(1'b1, PMX_OFS_PEND, 32'h00010000);
		wb(1'b0, PMX_OFS_PEND, 32'h0);
		check(bus_q, 32'h00020000);
		settle(2);
		check(irq_o, 1'b0);
		$display("irq test done");
	endtask : t_irq

	// Every function code on pins 0 to 5, then a software reset.
	task automatic t_fsel;
		logic [7:0] tbl;
		tbl = 8'b10_01_00_11;
		wb(1'b1, PMX_OFS_OUT, 32'h00000030);
		for (int c = 0; c < 4; c++)
		begin
			wb(1'b1, PMX_OFS_FSEL0, c[0] ? 32'h3F : 32'h0);
			wb(1'b1, PMX_OFS_FSEL1, c[1] ? 32'h3F : 32'h0);
			settle(1);
			check(pin_o[5:4], tbl[c*2+:2]);
			check(pin_o[3:0], c == 1 ? 4'h9 : 4'h0);
			check(pin_oe_o[3:0], c == 1 ? 4'hB : 4'hF);
		end
		@(posedge clk_i);
		soft_rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		soft_rst_i <= 1'b0;
		wb(1'b0, PMX_OFS_FSEL1, 32'h0);
		check(bus_q, 32'h3F);
		wb(1'b0, PMX_OFS_OUT, 32'h0);
		check(bus_q, 32'h0);
		$display("function test done");
	endtask : t_fsel

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test

	// Main sequence; a second external reset enters slave mode.
	initial
	begin
		t_reset(4'hA);
		t_io();
		t_irq();
		t_fsel();
		t_reset(4'hF);
		@(posedge clk_i);
		moe <= 1'b1;
		mdata <= 1'b1;
		settle(2);
		check({pin_oe_o[23], pin_o[23]}, 2'b11);
		end_of_test();
	end

	// Watchdog at 5000 cycles, well beyond the fewer than 200 cycles the tests need.
	initial
	begin
		#20000;
		error_cnt++;
		end_of_test();
	end
endmodule : test_pin_io_mux_controller
